// ==== rtl/cpu_rotate_sub_swap_xor_sleep.sv ====
// Execution core for rotate, subtract, swap, exclusive-OR and sleep, behind an Avalon-MM slave.
// Operation
// - Rotate right through carry, one position.
// - Destination 0 to accumulator, 1 to file.
// - File minus accumulator; carry, digit, zero updated.
// - Two's complement; carry and digit mean no borrow.
// - Literal minus accumulator into accumulator, flags updated.
// - Sleep clears power-down, sets time-out, clears watchdog.
// - Sleep halts core with oscillator stopped.
// - Swap nibbles to destination, flags untouched.
// - Literal XOR accumulator into accumulator, zero only.
// - File XOR accumulator to destination, zero only.
`timescale 1ns/1ps
module cpu_rotate_sub_swap_xor_sleep #(
   parameter int FILE_DEPTH = 128,
   parameter int PRESCALE_W = 8
) (
   // Clock and reset.
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Avalon-MM slave.
   input  wire logic [9:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Core state seen by the rest of the chip.
   output logic             osc_stop
);

   // The file index is seven bits wide, so the depth cannot be anything else.
   if (FILE_DEPTH != 128) begin : g_depth_check
      $error("FILE_DEPTH must be 128");
   end
   if (PRESCALE_W < 1 || PRESCALE_W > 16) begin : g_presc_check
      $error("PRESCALE_W must lie between 1 and 16");
   end

   // All state of the block.
   typedef struct packed {
      logic                            waitreq;     // Registered waitrequest, high when idle.
      logic [31:0]                     rdata;       // Registered read data.
      logic [7:0]                      acc;         // Accumulator.
      logic                            carry;       // Carry, clear means a borrow happened.
      logic                            digit;       // Digit borrow flag, same sense as carry.
      logic                            zero;        // Zero flag.
      logic                            time_out;    // Time-out flag, active low meaning.
      logic                            power_down;  // Power-down flag, active low meaning.
      logic                            asleep;      // Core halted, oscillator stopped.
      logic [7:0]                      watchdog;    // Watchdog counter.
      logic [PRESCALE_W-1:0]           prescale;    // Watchdog prescaler.
      logic [FILE_DEPTH-1:0][7:0]      file;        // File registers.
   } state_s;

   state_s s_q;                 // Registered state.
   state_s s_d;                 // Next state.

   logic                            bus_req;     // A read or write is being requested.
   logic                            bus_take;    // The request completes at this edge.
   logic                            cmd_take;    // A command write completes at this edge.
   logic                            exec;        // A legal command executes at this edge.
   logic [31:0]                     rd_mux;      // Read data for the current address.
   logic [6:0]                      bus_idx;     // File index from the bus address.
   logic [6:0]                      cmd_idx;     // File index from the command word.
   logic [2:0]                      cmd_op;      // Operation code from the command word.
   logic                            cmd_dest;    // Destination bit from the command word.
   logic [7:0]                      cmd_lit;     // Literal from the command word.
   logic [7:0]                      file_rd;     // Addressed file register.
   logic [7:0]                      alu_res;
   logic                            alu_c;
   logic                            alu_digit;
   logic                            alu_z;
   logic                            upd_c;
   logic                            upd_digit;
   logic                            upd_z;
   logic                            uses_dest;
   logic                            is_sleep;
   logic                            op_legal;

   // Bus request decode and command field extraction.
   always_comb begin
      bus_req  = avs_read | avs_write;
      bus_take = bus_req & ~s_q.waitreq;
      bus_idx  = avs_address[alu_core_pkg::FILE_IDX_LSB +: alu_core_pkg::FILE_IDX_W];
      cmd_op   = avs_writedata[alu_core_pkg::CMD_OP_LSB +: alu_core_pkg::CMD_OP_W];
      cmd_dest = avs_writedata[alu_core_pkg::CMD_DEST_BIT];
      cmd_idx  = avs_writedata[alu_core_pkg::CMD_ADDR_LSB +: alu_core_pkg::FILE_IDX_W];
      cmd_lit  = avs_writedata[alu_core_pkg::CMD_LIT_LSB +: 8];
      file_rd  = s_q.file[cmd_idx];
      // A halted core ignores commands; partial writes of the command word are ignored too.
      cmd_take = bus_take & avs_write & (avs_address == alu_core_pkg::OFS_CMD) & (&avs_byteenable)
                 & ~s_q.asleep;
      exec     = cmd_take & op_legal;
   end

   // Operation unit.
   alu_unit u_alu (
      .op        (cmd_op),
      .accum     (s_q.acc),
      .file_val  (file_rd),
      .literal   (cmd_lit),
      .carry_in  (s_q.carry),
      .result    (alu_res),
      .carry_out (alu_c),
      .digit_out (alu_digit),
      .zero_out  (alu_z),
      .upd_c     (upd_c),
      .upd_digit (upd_digit),
      .upd_z     (upd_z),
      .uses_dest (uses_dest),
      .is_sleep  (is_sleep),
      .legal     (op_legal)
   );

   // Read multiplexer; unmapped addresses read as zero.
   always_comb begin
      rd_mux = alu_core_pkg::WORD_ZERO;
      if (avs_address[alu_core_pkg::FILE_SEL_BIT]) begin
         rd_mux[7:0] = s_q.file[bus_idx];
      end else begin
         unique case (avs_address)
            alu_core_pkg::OFS_ACC: begin
               rd_mux[7:0] = s_q.acc;
            end
            alu_core_pkg::OFS_STATUS: begin
               rd_mux[alu_core_pkg::ST_CARRY] = s_q.carry;
               rd_mux[alu_core_pkg::ST_DIGIT] = s_q.digit;
               rd_mux[alu_core_pkg::ST_ZERO]  = s_q.zero;
               rd_mux[alu_core_pkg::ST_TIME_OUT]   = s_q.time_out;
               rd_mux[alu_core_pkg::ST_POWER_DOWN] = s_q.power_down;
               rd_mux[alu_core_pkg::ST_SLEEP] = s_q.asleep;
            end
            alu_core_pkg::OFS_WDOG: begin
               rd_mux[7:0]               = s_q.watchdog;
               rd_mux[8 +: PRESCALE_W]   = s_q.prescale;
            end
            default: begin
               rd_mux = alu_core_pkg::WORD_ZERO;
            end
         endcase
      end
   end

   // Next-state logic: bus handshake, watchdog, register writes and execution.
   always_comb begin
      s_d = s_q;
      // Each request waits exactly one cycle; waitrequest drops for one cycle to complete it.
      s_d.waitreq = 1'b1;
      if (bus_req && s_q.waitreq) begin
         s_d.waitreq = 1'b0;
         s_d.rdata   = rd_mux;
      end
      // The watchdog keeps running in sleep, as it would on its own oscillator.
      s_d.prescale = s_q.prescale + 1'b1;
      if (&s_q.prescale) begin
         s_d.watchdog = s_q.watchdog + 1'b1;
      end
      // Plain register writes use byte lane 0 only.
      if (bus_take && avs_write && avs_byteenable[0]) begin
         if (avs_address[alu_core_pkg::FILE_SEL_BIT]) begin
            s_d.file[bus_idx] = avs_writedata[7:0];
         end else if (avs_address == alu_core_pkg::OFS_ACC) begin
            s_d.acc = avs_writedata[7:0];
         end else if (avs_address == alu_core_pkg::OFS_STATUS) begin
            // Time-out and power-down are read-only to software.
            s_d.carry = avs_writedata[alu_core_pkg::ST_CARRY];
            s_d.digit = avs_writedata[alu_core_pkg::ST_DIGIT];
            s_d.zero  = avs_writedata[alu_core_pkg::ST_ZERO];
         end else if (avs_address == alu_core_pkg::OFS_WAKE) begin
            // Any write here stands in for a wake-up event.
            s_d.asleep = 1'b0;
         end
      end
      if (exec) begin
         if (is_sleep) begin
            s_d.power_down = 1'b0;
            s_d.time_out   = 1'b1;
            s_d.watchdog   = alu_core_pkg::WDOG_CLEAR;
            s_d.prescale   = '0;
            s_d.asleep     = 1'b1;
         end else begin
            // Literal forms always land in the accumulator.
            if (uses_dest && cmd_dest == alu_core_pkg::DEST_FILE) begin
               s_d.file[cmd_idx] = alu_res;
            end else begin
               s_d.acc = alu_res;
            end
            if (upd_c) begin
               s_d.carry = alu_c;
            end
            if (upd_digit) begin
               s_d.digit = alu_digit;
            end
            if (upd_z) begin
               s_d.zero = alu_z;
            end
         end
      end
   end

   // State register.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_q            <= '0;
         s_q.waitreq    <= 1'b1;
         s_q.time_out   <= alu_core_pkg::TIME_OUT_RESET;
         s_q.power_down <= alu_core_pkg::POWER_DOWN_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign avs_readdata    = s_q.rdata;
   assign avs_waitrequest = s_q.waitreq;
   assign osc_stop        = s_q.asleep;

   // Expected values used by the checks below.
   logic [7:0] rot_expect;
   logic [7:0] swap_expect;
   logic       ge_full;
   logic       ge_nib;
   always_comb begin
      rot_expect  = {s_q.carry, file_rd[7:1]};
      swap_expect = {file_rd[3:0], file_rd[7:4]};
      ge_full     = (file_rd >= s_q.acc);
      ge_nib      = (file_rd[3:0] >= s_q.acc[3:0]);
   end

   // Checks run on the core clock and stay quiet while reset is held.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_rotate_result: assert property (exec && cmd_op == 3'(alu_core_pkg::op_rotate_right_carry) && !cmd_dest
      |=> s_q.acc == $past(rot_expect) && s_q.carry == $past(file_rd[0]))
      else $error("rotate result or carry wrong");
   a_dest_file: assert property (exec && uses_dest && cmd_dest
      |=> $stable(s_q.acc))
      else $error("file destination disturbed accumulator");
   a_sub_carry: assert property (exec && cmd_op == 3'(alu_core_pkg::op_file_minus_accumulator)
      |=> s_q.carry == $past(ge_full) && s_q.digit == $past(ge_nib))
      else $error("subtract borrow flags wrong");
   a_sub_sum: assert property (exec && cmd_op == 3'(alu_core_pkg::op_file_minus_accumulator) && !cmd_dest
      |=> s_q.acc + $past(s_q.acc) == $past(file_rd))
      else $error("subtract result wrong");
   a_literal_sub: assert property (exec && cmd_op == 3'(alu_core_pkg::op_literal_minus_accumulator)
      |=> s_q.acc + $past(s_q.acc) == $past(cmd_lit) && s_q.carry == ($past(cmd_lit) >= $past(s_q.acc)))
      else $error("literal subtract wrong");
   a_sleep_flags: assert property (exec && is_sleep
      |=> s_q.time_out && !s_q.power_down && s_q.watchdog == 8'h00 && osc_stop)
      else $error("sleep side effects missing");
   a_sleep_halt: assert property (osc_stop && $stable(s_q.acc) ##1 osc_stop
      |-> $stable(s_q.carry) && $stable(s_q.zero))
      else $error("halted core changed flags");
   a_swap_result: assert property (exec && cmd_op == 3'(alu_core_pkg::op_nibble_exchange) && !cmd_dest
      |=> s_q.acc == $past(swap_expect) && $stable(s_q.carry) && $stable(s_q.zero))
      else $error("swap wrong or flags moved");
   a_xor_literal: assert property (exec && cmd_op == 3'(alu_core_pkg::op_literal_exclusive_or)
      |=> (s_q.acc ^ $past(s_q.acc)) == $past(cmd_lit) && $stable(s_q.carry))
      else $error("literal xor wrong");
   a_xor_zero: assert property (exec && cmd_op == 3'(alu_core_pkg::op_file_exclusive_or)
      |=> s_q.zero == ($past(file_rd) == $past(s_q.acc)) && $stable(s_q.digit))
      else $error("file xor zero flag wrong");
   a_zero_flag: assert property (exec && upd_z && !(uses_dest && cmd_dest)
      |=> s_q.zero == (s_q.acc == 8'h00))
      else $error("zero flag disagrees with result");

   // A rotate back into the file must land at the index named by the command.
   a_rotate_file: assert property (exec && cmd_op == 3'(alu_core_pkg::op_rotate_right_carry) && cmd_dest
      |=> s_q.file[$past(cmd_idx)] == $past(rot_expect))
      else $error("rotate into file wrong");

   // The literal form has no destination bit, so the file must stay untouched even if the bit is set.
   a_literal_dest: assert property (exec && cmd_op == 3'(alu_core_pkg::op_literal_minus_accumulator)
      |=> $stable(s_q.file))
      else $error("literal subtract wrote a file register");

   // A stale prescaler would make the first watchdog step after sleep come early.
   a_sleep_prescale: assert property (exec && is_sleep
      |=> s_q.prescale == '0)
      else $error("sleep left the prescaler running");

   // A command word that completes while halted must not reach the working registers.
   a_halt_ignore: assert property (osc_stop && avs_write && !avs_waitrequest
      && avs_address == alu_core_pkg::OFS_CMD
      |=> $stable(s_q.acc) && $stable(s_q.file) && $stable(s_q.zero))
      else $error("halted core executed a command");

   // A swap back into the file must land at the index named by the command.
   a_swap_file: assert property (exec && cmd_op == 3'(alu_core_pkg::op_nibble_exchange) && cmd_dest
      |=> s_q.file[$past(cmd_idx)] == $past(swap_expect))
      else $error("swap into file wrong");

   // Every request sees exactly one wait cycle, so a master may rely on a prompt answer.
   a_wait_answer: assert property (avs_waitrequest && (avs_read || avs_write)
      |=> !avs_waitrequest)
      else $error("request not answered after one wait cycle");

   // Waitrequest drops for one cycle only, so a held request is not taken on two edges in a row.
   a_wait_single: assert property (!avs_waitrequest
      |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");

endmodule

// ==== rtl/alu_core_pkg.sv ====
// Shared constants and types for the rotate, subtract, swap, exclusive-OR and sleep datapath.
package alu_core_pkg;

   // Avalon-MM slave geometry.
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;

   // Control register byte offsets.
   localparam logic [ADDR_W-1:0] OFS_CMD    = 10'h000;
   localparam logic [ADDR_W-1:0] OFS_ACC    = 10'h004;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 10'h008;
   localparam logic [ADDR_W-1:0] OFS_WAKE   = 10'h00C;
   localparam logic [ADDR_W-1:0] OFS_WDOG   = 10'h010;

   // The file registers sit at 0x200 plus four times their index.
   localparam int FILE_SEL_BIT = 9;
   localparam int FILE_IDX_LSB = 2;
   localparam int FILE_IDX_W   = 7;

   // Command word fields.
   localparam int CMD_OP_LSB   = 0;
   localparam int CMD_OP_W     = 3;
   localparam int CMD_DEST_BIT = 4;
   localparam int CMD_ADDR_LSB = 8;
   localparam int CMD_LIT_LSB  = 16;

   // Status register bit positions.
   localparam int ST_CARRY      = 0;
   localparam int ST_DIGIT      = 1;
   localparam int ST_ZERO       = 2;
   localparam int ST_TIME_OUT   = 3;
   localparam int ST_POWER_DOWN = 4;
   localparam int ST_SLEEP      = 5;

   // Destination field encoding.
   localparam logic DEST_ACC  = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   // Reset and clear values.
   localparam logic [7:0]        BYTE_ZERO        = 8'h00;
   localparam logic [7:0]        WDOG_CLEAR       = 8'h00;
   localparam logic [DATA_W-1:0] WORD_ZERO        = 32'h0000_0000;
   localparam logic              TIME_OUT_RESET   = 1'b1;
   localparam logic              POWER_DOWN_RESET = 1'b1;

   // Instruction codes; the one code left over is illegal and ignored.
   typedef enum logic [CMD_OP_W-1:0] {
      op_rotate_right_carry,
      op_file_minus_accumulator,
      op_literal_minus_accumulator,
      op_nibble_exchange,
      op_literal_exclusive_or,
      op_file_exclusive_or,
      op_sleep
   } op_e;

endpackage

// ==== rtl/alu_unit.sv ====
// Combinational operation unit: result, flags and which flags each operation touches.
`timescale 1ns/1ps
module alu_unit (
   // Operation select.
   input  wire logic [2:0] op,
   // Operands.
   input  wire logic [7:0] accum,
   input  wire logic [7:0] file_val,
   input  wire logic [7:0] literal,
   input  wire logic       carry_in,
   // Result and flags.
   output logic [7:0]      result,
   output logic            carry_out,
   output logic            digit_out,
   output logic            zero_out,
   // Which state the operation may change.
   output logic            upd_c,
   output logic            upd_digit,
   output logic            upd_z,
   output logic            uses_dest,
   output logic            is_sleep,
   output logic            legal
);

   logic [7:0] sub_a;      // Minuend: file register or literal.
   logic [8:0] diff;       // Nine-bit two's complement difference.
   logic [4:0] nib;        // Low-nibble difference for the digit borrow.

   // Subtraction adds the inverted accumulator plus one, so bit 8 is set when no borrow occurs.
   always_comb begin
      sub_a = (alu_core_pkg::op_e'(op) == alu_core_pkg::op_literal_minus_accumulator) ? literal : file_val;
      diff  = {1'b0, sub_a} + {1'b0, ~accum} + 9'h001;
      nib   = {1'b0, sub_a[3:0]} + {1'b0, ~accum[3:0]} + 5'h01;
   end

   // Operation decode.
   always_comb begin
      result    = accum;
      carry_out = carry_in;
      digit_out = 1'b0;
      upd_c     = 1'b0;
      upd_digit = 1'b0;
      upd_z     = 1'b0;
      uses_dest = 1'b0;
      is_sleep  = 1'b0;
      legal     = 1'b1;
      unique case (alu_core_pkg::op_e'(op))
         alu_core_pkg::op_rotate_right_carry: begin
            // Old carry enters bit 7 and bit 0 leaves as the new carry.
            result    = {carry_in, file_val[7:1]};
            carry_out = file_val[0];
            upd_c     = 1'b1;
            uses_dest = 1'b1;
         end
         alu_core_pkg::op_file_minus_accumulator: begin
            result    = diff[7:0];
            carry_out = diff[8];
            digit_out = nib[4];
            upd_c     = 1'b1;
            upd_digit = 1'b1;
            upd_z     = 1'b1;
            uses_dest = 1'b1;
         end
         alu_core_pkg::op_literal_minus_accumulator: begin
            result    = diff[7:0];
            carry_out = diff[8];
            digit_out = nib[4];
            upd_c     = 1'b1;
            upd_digit = 1'b1;
            upd_z     = 1'b1;
         end
         alu_core_pkg::op_nibble_exchange: begin
            // No flag is touched by the swap.
            result    = {file_val[3:0], file_val[7:4]};
            uses_dest = 1'b1;
         end
         alu_core_pkg::op_literal_exclusive_or: begin
            result    = accum ^ literal;
            upd_z     = 1'b1;
         end
         alu_core_pkg::op_file_exclusive_or: begin
            result    = accum ^ file_val;
            upd_z     = 1'b1;
            uses_dest = 1'b1;
         end
         alu_core_pkg::op_sleep: begin
            is_sleep  = 1'b1;
         end
         default: begin
            legal     = 1'b0;
         end
      endcase
      zero_out = (result == 8'h00);
   end

endmodule

// ==== sim/cpu_rotate_sub_swap_xor_sleep_tb.sv ====
// Self-checking bench for the rotate, subtract, swap, exclusive-OR and sleep core.
`timescale 1ns/1ps
module cpu_rotate_sub_swap_xor_sleep_tb;
   // Clock and reset.
   logic        ref_clk;
   logic        rst;
   // Avalon-MM master side.
   logic [9:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        osc_stop;
   // Mismatch and comparison counters.
   int          n_fail;
   int          checked;
   // Subtraction operand tables: accumulator and file or literal value.
   logic [7:0]  tw [5] = '{8'h05, 8'h06, 8'h0F, 8'h21, 8'h00};
   logic [7:0]  tf [5] = '{8'h05, 8'h05, 8'h20, 8'h13, 8'hFF};
   // Scratch for expectations and read data.
   logic [7:0]  r;
   logic        c;
   logic        dg;
   logic        z;
   logic [6:0]  x;
   logic [31:0] q;

   cpu_rotate_sub_swap_xor_sleep DUT (
      .ref_clk         (ref_clk),
      .rst             (rst),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (avs_byteenable),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .osc_stop        (osc_stop)
   );

   // Free-running 20 MHz clock.
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("TB: checked=%0d failed=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Compares one bus word against its expected value.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One bus transfer; the request is held until waitrequest is sampled low.
   task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] rq);
      int n;
      @(posedge ref_clk);
      avs_address    <= a;
      avs_write      <= wr;
      avs_read       <= ~wr;
      avs_writedata  <= d;
      avs_byteenable <= be;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      // A slave that never answers ends the run as a failure.
      if (avs_waitrequest !== 1'b0) begin
         n_fail++;
         report_and_stop();
      end
      rq = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   // Full-word register write.
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      xfer(1'b1, a, d, 4'hF, dummy);
   endtask

   // Register read compared against an expected word.
   task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
      logic [31:0] got;
      xfer(1'b0, a, 32'h0000_0000, 4'hF, got);
      check(got, exp);
   endtask

   // Issues one instruction through the command word.
   task automatic cmd(input logic [2:0] op, input logic d, input logic [6:0] fx, input logic [7:0] k);
      wr(alu_core_pkg::OFS_CMD, {8'h00, k, 1'b0, fx, 3'h0, d, 1'b0, op});
   endtask

   // Byte address of file register fx.
   function automatic logic [9:0] fa(input logic [6:0] fx);
      return {1'b1, fx, 2'h0};
   endfunction

   // Status word while awake with time-out and power-down both set.
   function automatic logic [31:0] st(input logic zf, input logic df, input logic cf);
      return {27'h000_0000, 2'h3, zf, df, cf};
   endfunction

   // Main sequence.
   initial begin
      n_fail = 0;
      checked = 0;
      rst = 1'b1;
      avs_address = 10'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'h0;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      rd_chk(alu_core_pkg::OFS_STATUS, st(1'b0, 1'b0, 1'b0));
      rd_chk(alu_core_pkg::OFS_ACC, 32'h0000_0000);
      // Rotate into the file with carry clear, then into the accumulator with carry set.
      wr(fa(7'h05), 32'h0000_0081);
      wr(alu_core_pkg::OFS_STATUS, 32'h0000_0000);
      cmd(alu_core_pkg::op_rotate_right_carry, 1'b1, 7'h05, 8'h00);
      rd_chk(fa(7'h05), 32'h0000_0040);
      rd_chk(alu_core_pkg::OFS_STATUS, st(1'b0, 1'b0, 1'b1));
      cmd(alu_core_pkg::op_rotate_right_carry, 1'b0, 7'h05, 8'h00);
      rd_chk(alu_core_pkg::OFS_ACC, 32'h0000_00A0);
      rd_chk(fa(7'h05), 32'h0000_0040);
      rd_chk(alu_core_pkg::OFS_STATUS, st(1'b0, 1'b0, 1'b0));
      // Both subtractions over equal, borrow, digit-borrow and wrap-around operands.
      for (int i = 0; i < 5; i++) begin
         x = 7'(i + 10);
         r = tf[i] - tw[i];
         c = (tw[i] <= tf[i]);
         dg = (tw[i][3:0] <= tf[i][3:0]);
         z = (r == 8'h00);
         wr(alu_core_pkg::OFS_ACC, {24'h00_0000, tw[i]});
         wr(fa(x), {24'h00_0000, tf[i]});
         cmd(alu_core_pkg::op_file_minus_accumulator, i[0], x, 8'h00);
         rd_chk(i[0] ? fa(x) : alu_core_pkg::OFS_ACC, {24'h00_0000, r});
         rd_chk(i[0] ? alu_core_pkg::OFS_ACC : fa(x), {24'h00_0000, i[0] ? tw[i] : tf[i]});
         rd_chk(alu_core_pkg::OFS_STATUS, st(z, dg, c));
         wr(alu_core_pkg::OFS_ACC, {24'h00_0000, tw[i]});
         wr(alu_core_pkg::OFS_STATUS, 32'h0000_0000);
         cmd(alu_core_pkg::op_literal_minus_accumulator, 1'b1, 7'h00, tf[i]);
         rd_chk(alu_core_pkg::OFS_ACC, {24'h00_0000, r});
         rd_chk(alu_core_pkg::OFS_STATUS, st(z, dg, c));
      end
      // Nibble swap at the top file index must leave every flag alone.
      wr(alu_core_pkg::OFS_STATUS, 32'h0000_0003);
      wr(fa(7'h7F), 32'h0000_00A5);
      cmd(alu_core_pkg::op_nibble_exchange, 1'b0, 7'h7F, 8'h00);
      rd_chk(alu_core_pkg::OFS_ACC, 32'h0000_005A);
      cmd(alu_core_pkg::op_nibble_exchange, 1'b1, 7'h7F, 8'h00);
      rd_chk(fa(7'h7F), 32'h0000_005A);
      rd_chk(alu_core_pkg::OFS_STATUS, st(1'b0, 1'b1, 1'b1));
      // Literal XOR to zero touches only the zero flag.
      cmd(alu_core_pkg::op_literal_exclusive_or, 1'b1, 7'h00, 8'h5A);
      rd_chk(alu_core_pkg::OFS_ACC, 32'h0000_0000);
      rd_chk(alu_core_pkg::OFS_STATUS, st(1'b1, 1'b1, 1'b1));
      // File XOR to both destinations.
      wr(alu_core_pkg::OFS_ACC, 32'h0000_000F);
      cmd(alu_core_pkg::op_file_exclusive_or, 1'b1, 7'h7F, 8'h00);
      rd_chk(fa(7'h7F), 32'h0000_0055);
      rd_chk(alu_core_pkg::OFS_ACC, 32'h0000_000F);
      rd_chk(alu_core_pkg::OFS_STATUS, st(1'b0, 1'b1, 1'b1));
      cmd(alu_core_pkg::op_file_exclusive_or, 1'b0, 7'h7F, 8'h00);
      rd_chk(alu_core_pkg::OFS_ACC, 32'h0000_005A);
      // Illegal opcode and partial lanes change nothing; an unmapped address reads as zero.
      cmd(3'h7, 1'b0, 7'h7F, 8'hFF);
      xfer(1'b1, alu_core_pkg::OFS_CMD, 32'h00FF_0004, 4'h1, q);
      rd_chk(alu_core_pkg::OFS_ACC, 32'h0000_005A);
      rd_chk(10'h020, 32'h0000_0000);
      // Let the watchdog take a few steps first, so that its clear by sleep can be seen.
      repeat (600) @(posedge ref_clk);
      xfer(1'b0, alu_core_pkg::OFS_WDOG, 32'h0000_0000, 4'hF, q);
      check({31'h0000_0000, q[7:0] != 8'h00}, 32'h0000_0001);
      cmd(alu_core_pkg::op_sleep, 1'b0, 7'h00, 8'h00);
      xfer(1'b0, alu_core_pkg::OFS_WDOG, 32'h0000_0000, 4'hF, q);
      check({24'h00_0000, q[7:0]}, 32'h0000_0000);
      check({31'h0000_0000, q[15:8] < 8'h08}, 32'h0000_0001);
      check({31'h0000_0000, osc_stop}, 32'h0000_0001);
      rd_chk(alu_core_pkg::OFS_STATUS, 32'h0000_002B);
      // A halted core ignores further instructions until woken.
      cmd(alu_core_pkg::op_literal_exclusive_or, 1'b0, 7'h00, 8'hFF);
      rd_chk(alu_core_pkg::OFS_ACC, 32'h0000_005A);
      wr(alu_core_pkg::OFS_WAKE, 32'h0000_0001);
      // The wake lands at the completing edge, so look half a cycle later.
      @(negedge ref_clk);
      check({31'h0000_0000, osc_stop}, 32'h0000_0000);
      rd_chk(alu_core_pkg::OFS_STATUS, 32'h0000_000B);
      report_and_stop();
   end
endmodule
